// File: rtl/rpe_pkg.sv
// Purpose: constants and types shared by the register paging and event block
// Assumes: byte-wide registers, nine-bit physical register space
// Notes: offsets below are physical addresses after page mapping
//
// Notes on behaviour
// - With auto page return set, page field goes to 000 at the end-of-frame access.
// - Two-wire multi-byte write: mode bit 0 gives page write, 1 repeated write.
// - Four-wire accesses ignore the write-mode bit.
// - Two-wire: page 00x reaches 0x00-0xFF, 01x reaches 0x100-0x17F.
// - Four-wire: page 000, 001, 010 reach 0x00, 0x80, 0x100 windows of 128.
// - Status reads return live monitored levels, general inputs in bits 4..0.
// - Status bits 7 and 6 low while regulator A, B ramps or powers up/down.
// - Status bits 5 and 4 high while regulator B, A is at current limit.
// - Status bit 3 shows thermal shutdown, bit 2 thermal warning.
// - Status bits 1 and 0 high while regulator B, A output is in range.
// - A rise of undervoltage, over-current or thermal, a range loss or a general input going active sets its event bit; ramps set none.
// - Interrupt asserts whenever any unmasked event bit is set.
// - Host clears events by writing back read value; ones clear exactly.
// - Events arising during a clearing write are held and latched afterward.
// - First event register: bit 6 undervoltage, bits 4..0 general inputs by polarity.
// - Second event register: over-current 5,4; thermal 3,2; range loss 1,0.
// - First mask register: bit 6 masks undervoltage, bits 4..0 general inputs.
// - Over-current masks block event and interrupt; others block interrupt only.
package rpe_pkg;
	// --------------------------------------------------------------
	// Register offsets (physical)
	// --------------------------------------------------------------
	localparam logic [8:0] OFS_PAGE_CTL0 = 9'h000;
	localparam logic [8:0] OFS_PAGE_CTL1 = 9'h080;
	localparam logic [8:0] OFS_PAGE_CTL2 = 9'h100;
	localparam logic [8:0] OFS_STATUS_IN = 9'h050;
	localparam logic [8:0] OFS_STATUS_REG = 9'h051;
	localparam logic [8:0] OFS_EVENT_IN = 9'h052;
	localparam logic [8:0] OFS_EVENT_REG = 9'h053;
	localparam logic [8:0] OFS_MASK_IN = 9'h054;
	localparam logic [8:0] OFS_MASK_REG = 9'h055;
	// --------------------------------------------------------------
	// Field positions and layouts
	// --------------------------------------------------------------
	localparam int PC_AUTORET_BIT = 7;
	localparam int PC_WMODE_BIT = 6;
	localparam logic [7:0] PC_USED = 8'hC7;
	localparam logic [7:0] EVIN_USED = 8'h5F;
	localparam logic [7:0] EVREG_USED = 8'h3F;
	localparam logic [7:0] EVREG_CURLIM = 8'h30;
	localparam logic [2:0] PAGE_LAST_SPI = 3'h2;
	localparam int GPI_COUNT = 5;
	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [7:0] RST_PAGE_CTL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_EVENT = 8'h00;
	localparam logic [7:0] RST_OFS = 8'h00;
	// Access kinds handed over from the serial front end
	typedef enum logic [1:0] {
		RPE_OP_WRITE = 2'b00,
		RPE_OP_READ = 2'b01,
		RPE_OP_END = 2'b10,
		RPE_OP_NONE = 2'b11
	} rpe_op_t;
endpackage

// File: rtl/rpe_core.sv
// Purpose: register paging, live status, event latching and interrupt output
// Assumes: serial protocol engine on linkClk hands over one byte access at a time
// Notes: link handshake is a toggle pair; held fields stay stable while busy
`timescale 1ns/1ps
module rpe_core
	import rpe_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic linkClk,
	input wire logic linkReq,
	input wire rpe_op_t linkOp,
	input wire logic linkNewAddr,
	input wire logic [7:0] linkAddr,
	input wire logic [7:0] linkData,
	input wire logic linkFourWire,
	output logic linkReady,
	output logic [7:0] linkRdData,
	output logic linkRdValid,
	input wire logic [4:0] generalInput,
	input wire logic [4:0] inputActiveHigh,
	input wire logic voltageRampFirst,
	input wire logic voltageRampSecond,
	input wire logic currentLimitFirst,
	input wire logic currentLimitSecond,
	input wire logic thermalShutdownFlag,
	input wire logic thermalWarning,
	input wire logic outputInRangeFirst,
	input wire logic outputInRangeSecond,
	input wire logic ioSupplyUndervoltage,
	output logic interruptOutLow
);
	// --------------------------------------------------------------
	// Link domain: hold one access and toggle a request
	// --------------------------------------------------------------
	rpe_op_t heldOp;
	logic heldNewAddr;
	logic [7:0] heldAddr;
	logic [7:0] heldData;
	logic heldFourWire;
	logic reqTog;
	logic linkBusy;
	logic [SYNC_STAGES-1:0] ackSync;
	logic ackSeen;
	logic ackTog;
	logic [7:0] coreRdData;
	wire ackPulse = ackSync[SYNC_STAGES-1] ^ ackSeen;
	wire linkTake = linkReq && !linkBusy;

	// Busy until the core answers, so held fields never change mid-crossing
	assign linkReady = !linkBusy;

	// Capture the access and flip the request toggle
	always_ff @(posedge linkClk or negedge arst_n) begin
		if (!arst_n) begin
			heldOp <= RPE_OP_NONE;
			heldNewAddr <= 1'b0;
			heldAddr <= 8'h00;
			heldData <= 8'h00;
			heldFourWire <= 1'b0;
			reqTog <= 1'b0;
		end else if (linkTake) begin
			heldOp <= linkOp;
			heldNewAddr <= linkNewAddr;
			heldAddr <= linkAddr;
			heldData <= linkData;
			heldFourWire <= linkFourWire;
			reqTog <= ~reqTog;
		end
	end

	// Answer side: acknowledge toggle back to the link clock
	always_ff @(posedge linkClk or negedge arst_n) begin
		if (!arst_n) begin
			ackSync <= '0;
			ackSeen <= 1'b0;
			linkBusy <= 1'b0;
			linkRdData <= 8'h00;
			linkRdValid <= 1'b0;
		end else begin
			ackSync <= {ackSync[SYNC_STAGES-2:0], ackTog};
			ackSeen <= ackSync[SYNC_STAGES-1];
			linkBusy <= linkTake ? 1'b1 : (ackPulse ? 1'b0 : linkBusy);
			linkRdValid <= ackPulse && (heldOp == RPE_OP_READ);
			if (ackPulse) begin
				linkRdData <= coreRdData; // Stable: core holds it until the next request
			end
		end
	end

	// Held link state may not outlive a request
	chk_link_busy: assert property (@(posedge linkClk) disable iff (!arst_n)
		linkTake |=> !linkReady)
		else $error("link ready while an access is in flight");

	// --------------------------------------------------------------
	// Core domain: request detection
	// --------------------------------------------------------------
	logic [SYNC_STAGES-1:0] reqSync;
	logic reqSeen;
	wire reqPulse = reqSync[SYNC_STAGES-1] ^ reqSeen;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reqSync <= '0;
			reqSeen <= 1'b0;
		end else begin
			reqSync <= {reqSync[SYNC_STAGES-2:0], reqTog};
			reqSeen <= reqSync[SYNC_STAGES-1];
		end
	end

	// --------------------------------------------------------------
	// Address generation and page mapping
	// --------------------------------------------------------------
	logic [7:0] pageCtl;
	logic [7:0] curOfs;
	logic expectAddr;
	wire [2:0] pageSel = pageCtl[2:0];
	wire autoReturn = pageCtl[PC_AUTORET_BIT];
	wire repeatedMode = pageCtl[PC_WMODE_BIT] && !heldFourWire;
	wire isAccess = (heldOp == RPE_OP_WRITE) || (heldOp == RPE_OP_READ);
	wire [7:0] effOfs = heldNewAddr ? heldAddr : curOfs;
	// Continuation byte in repeated write mode names the next register
	wire addrByte = (heldOp == RPE_OP_WRITE) && !heldNewAddr && repeatedMode && expectAddr;
	wire doAccess = reqPulse && isAccess && !addrByte;
	wire doWrite = doAccess && (heldOp == RPE_OP_WRITE);
	wire doRead = doAccess && (heldOp == RPE_OP_READ);

	// Two-wire uses an 8-bit offset, four-wire a 7-bit one
	wire [8:0] physTwo = pageSel[1] ? {2'b10, effOfs[6:0]} : {1'b0, effOfs};
	wire mapTwo = !pageSel[2] && !(pageSel[1] && effOfs[7]);
	wire [8:0] physFour = {pageSel[1:0], effOfs[6:0]};
	wire mapFour = pageSel <= PAGE_LAST_SPI;
	wire [8:0] physAddr = heldFourWire ? physFour : physTwo;
	wire mapped = heldFourWire ? mapFour : mapTwo;

	// Register select decode
	wire selPage = mapped && (physAddr == OFS_PAGE_CTL0 || physAddr == OFS_PAGE_CTL1 ||
		physAddr == OFS_PAGE_CTL2);
	wire selStaIn = mapped && (physAddr == OFS_STATUS_IN);
	wire selStaReg = mapped && (physAddr == OFS_STATUS_REG);
	wire selEvIn = mapped && (physAddr == OFS_EVENT_IN);
	wire selEvReg = mapped && (physAddr == OFS_EVENT_REG);
	wire selMaskIn = mapped && (physAddr == OFS_MASK_IN);
	wire selMaskReg = mapped && (physAddr == OFS_MASK_REG);

	// Offset pointer: explicit address, auto-increment or address byte
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			curOfs <= RST_OFS;
			expectAddr <= 1'b0;
		end else if (reqPulse && isAccess) begin
			curOfs <= addrByte ? heldData : 8'(effOfs + 8'h01);
			expectAddr <= (heldOp == RPE_OP_WRITE) && repeatedMode && !addrByte;
		end
	end

	// Four-wire continuation always increments whatever the mode bit says
	chk_four_increment: assert property (@(posedge core_clk) disable iff (!arst_n)
		reqPulse && heldOp == RPE_OP_WRITE && heldFourWire && !heldNewAddr
		|=> curOfs == 8'($past(curOfs) + 8'h01))
		else $error("four-wire write did not advance the offset");

	// --------------------------------------------------------------
	// Monitored signals: two-flop synchronisers and previous value
	// --------------------------------------------------------------
	localparam int MON_W = 14;
	wire [MON_W-1:0] monRaw = {ioSupplyUndervoltage, outputInRangeSecond, outputInRangeFirst,
		thermalWarning, thermalShutdownFlag, currentLimitSecond, currentLimitFirst,
		voltageRampSecond, voltageRampFirst, generalInput};
	logic [MON_W-1:0] monMeta;
	logic [MON_W-1:0] monNow;
	logic [MON_W-1:0] monPrev;
	logic [2:0] primeChain;
	// Third edge after release is the first with a real sample in monPrev
	wire monPrimed = primeChain[2];

	// Prev is only trusted once a real sample exists, avoiding reset-edge events
	// Pins that already sit high at release therefore raise no event
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			monMeta <= '0;
			monNow <= '0;
			monPrev <= '0;
			primeChain <= 3'b000;
		end else begin
			monMeta <= monRaw;
			monNow <= monMeta;
			monPrev <= monNow;
			primeChain <= {primeChain[1:0], 1'b1};
		end
	end

	// Field split of the synchronised vector
	wire [4:0] gpiNow = monNow[4:0];
	wire [4:0] gpiPrev = monPrev[4:0];
	wire rampFirst = monNow[5];
	wire rampSecond = monNow[6];
	wire [1:0] climNow = monNow[8:7];
	wire [1:0] climPrev = monPrev[8:7];
	wire [1:0] thermNow = {monNow[9], monNow[10]};
	wire [1:0] thermPrev = {monPrev[9], monPrev[10]};
	wire [1:0] rangeNow = monNow[12:11];
	wire [1:0] rangePrev = monPrev[12:11];
	wire uvNow = monNow[13];
	wire uvPrev = monPrev[13];

	// Live status images, read straight from the synchronisers
	wire [7:0] statusIn = {3'b000, gpiNow};
	wire [7:0] statusReg = {~rampFirst, ~rampSecond, climNow[1], climNow[0],
		thermNow, rangeNow[1], rangeNow[0]};

	// --------------------------------------------------------------
	// Event detection
	// --------------------------------------------------------------
	logic [7:0] maskIn;
	logic [7:0] maskReg;
	wire [4:0] gpiEvent;

	// Each input fires on entering its configured active state
	genvar gi;
	generate
		for (gi = 0; gi < GPI_COUNT; gi++) begin : gen_gpi_event
			assign gpiEvent[gi] = monPrimed && (inputActiveHigh[gi] ?
				(gpiNow[gi] && !gpiPrev[gi]) : (!gpiNow[gi] && gpiPrev[gi]));
		end
	endgenerate

	wire uvEvent = monPrimed && uvNow && !uvPrev;
	wire [1:0] climEvent = {2{monPrimed}} & climNow & ~climPrev;
	wire [1:0] thermEvent = {2{monPrimed}} & thermNow & ~thermPrev;
	wire [1:0] rangeLoss = {2{monPrimed}} & ~rangeNow & rangePrev;
	wire [7:0] newIn = {1'b0, uvEvent, 1'b0, gpiEvent} & EVIN_USED;
	// Over-current mask stops the latch itself, not only the interrupt
	wire [7:0] newReg = {2'b00, climEvent, thermEvent, rangeLoss} & ~(maskReg & EVREG_CURLIM);

	// --------------------------------------------------------------
	// Event latches with hold-over during clearing writes
	// --------------------------------------------------------------
	logic [7:0] eventIn;
	logic [7:0] eventReg;
	logic [7:0] heldIn;
	logic [7:0] heldReg;
	wire [7:0] clrIn = (doWrite && selEvIn) ? (heldData & EVIN_USED) : 8'h00;
	wire [7:0] clrReg = (doWrite && selEvReg) ? (heldData & EVREG_USED) : 8'h00;
	wire clearing = (clrIn != 8'h00) || (clrReg != 8'h00);
	// New events during a clear are parked, older parked ones land now
	wire [7:0] next_eventIn = (eventIn & ~clrIn) | heldIn | (clearing ? 8'h00 : newIn);
	wire [7:0] next_eventReg = (eventReg & ~clrReg) | heldReg | (clearing ? 8'h00 : newReg);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			eventIn <= RST_EVENT;
			eventReg <= RST_EVENT;
			heldIn <= RST_EVENT;
			heldReg <= RST_EVENT;
		end else begin
			eventIn <= next_eventIn;
			eventReg <= next_eventReg;
			heldIn <= clearing ? newIn : 8'h00;
			heldReg <= clearing ? newReg : 8'h00;
		end
	end

	chk_clear_exact: assert property (@(posedge core_clk) disable iff (!arst_n)
		clrReg != 8'h00 && heldReg == 8'h00 |=> eventReg == ($past(eventReg) & ~$past(clrReg)))
		else $error("clearing write did not clear exactly the ones written");

	chk_held_event: assert property (@(posedge core_clk) disable iff (!arst_n)
		clearing && newIn != 8'h00 |=> ##1 (eventIn & $past(newIn, 2)) == $past(newIn, 2))
		else $error("event during a clear was lost");

	chk_range_loss: assert property (@(posedge core_clk) disable iff (!arst_n)
		monPrimed && rangePrev[0] && !rangeNow[0] |-> ##[1:2] eventReg[0])
		else $error("range loss did not latch its event");

	chk_curlim_block: assert property (@(posedge core_clk) disable iff (!arst_n)
		maskReg[4] && !eventReg[4] && !heldReg[4] |=> !eventReg[4])
		else $error("masked over-current event latched");

	// Entering the active level latches, one cycle later if a clear parks it
	chk_gpi_event: assert property (@(posedge core_clk) disable iff (!arst_n)
		monPrimed && inputActiveHigh[0] && gpiNow[0] && !gpiPrev[0] |-> ##[1:2] eventIn[0])
		else $error("general input event not latched");

	// Supply undervoltage latches on its rising edge
	chk_uv_event: assert property (@(posedge core_clk) disable iff (!arst_n)
		monPrimed && uvNow && !uvPrev |-> ##[1:2] eventIn[6])
		else $error("undervoltage event not latched");

	// --------------------------------------------------------------
	// Control registers: page control and masks
	// --------------------------------------------------------------
	wire endFrame = reqPulse && (heldOp == RPE_OP_END);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pageCtl <= RST_PAGE_CTL;
			maskIn <= RST_MASK;
			maskReg <= RST_MASK;
		end else begin
			if (doWrite && selPage) begin
				pageCtl <= heldData & PC_USED;
			end else if (endFrame && autoReturn) begin
				pageCtl <= {pageCtl[7:3], 3'b000};
			end
			if (doWrite && selMaskIn) begin
				maskIn <= heldData & EVIN_USED;
			end
			if (doWrite && selMaskReg) begin
				maskReg <= heldData & EVREG_USED;
			end
		end
	end

	chk_page_return: assert property (@(posedge core_clk) disable iff (!arst_n)
		endFrame && autoReturn |=> pageCtl[2:0] == 3'b000 && pageCtl[PC_AUTORET_BIT])
		else $error("page field not returned to zero at access end");

	// --------------------------------------------------------------
	// Read mux and acknowledge
	// --------------------------------------------------------------
	wire [7:0] readMux = selPage ? pageCtl :
		selStaIn ? statusIn :
		selStaReg ? statusReg :
		selEvIn ? eventIn :
		selEvReg ? eventReg :
		selMaskIn ? maskIn :
		selMaskReg ? maskReg : 8'h00; // Unmapped or other blocks read zero

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			coreRdData <= 8'h00;
			ackTog <= 1'b0;
		end else begin
			if (doRead) begin
				coreRdData <= readMux;
			end
			if (reqPulse) begin
				ackTog <= ~ackTog;
			end
		end
	end

	chk_status_read: assert property (@(posedge core_clk) disable iff (!arst_n)
		doRead && selStaReg |=> coreRdData == {~$past(monNow[5]), ~$past(monNow[6]), $past(monNow[8]),
		$past(monNow[7]), $past(monNow[9]), $past(monNow[10]), $past(monNow[12]), $past(monNow[11])})
		else $error("status read did not return live levels");

	// --------------------------------------------------------------
	// Interrupt output
	// --------------------------------------------------------------
	wire irqWanted = ((eventIn & ~maskIn) != 8'h00) || ((eventReg & ~maskReg) != 8'h00);

	// Registered so the pin never glitches from the decode
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			interruptOutLow <= 1'b1;
		end else begin
			interruptOutLow <= !irqWanted;
		end
	end

	chk_irq_assert: assert property (@(posedge core_clk) disable iff (!arst_n)
		irqWanted |=> !interruptOutLow)
		else $error("unmasked event without interrupt");

	chk_irq_release: assert property (@(posedge core_clk) disable iff (!arst_n)
		!interruptOutLow && !irqWanted |=> interruptOutLow)
		else $error("interrupt held after all events cleared");
endmodule

// File: verification/rpe_link_host.sv
// Purpose: host-side link model issuing byte accesses to the paging block
// Assumes: one access in flight; the link clock runs inside frames and for 8 edges during reset
// Notes: idle address and data lines carry the inverse of their last value
`timescale 1ns/1ps
module rpe_link_host
	import rpe_pkg::*;
(
	output logic linkClk,
	output logic linkReq,
	output rpe_op_t linkOp,
	output logic linkNewAddr,
	output logic [7:0] linkAddr,
	output logic [7:0] linkData,
	output logic linkFourWire,
	input wire logic linkReady,
	input wire logic [7:0] linkRdData,
	input wire logic linkRdValid
);
	logic clkRun;
	logic timedOut;
	logic [7:0] lastRead;
	// Gated link clock parked low; odd start offset keeps it apart from the core clock
	initial begin
		linkClk = 1'b0;
		clkRun = 1'b1;
		timedOut = 1'b0;
		lastRead = 8'h00;
		linkReq = 1'b0;
		linkOp = RPE_OP_NONE;
		linkNewAddr = 1'b0;
		linkAddr = 8'h00;
		linkData = 8'h00;
		linkFourWire = 1'b0;
		#7;
		forever begin
			#24;
			if (clkRun || linkClk) begin
				linkClk = ~linkClk;
			end
		end
	end
	// A few edges during reset, then parked until the first frame
	initial begin
		repeat (8) @(posedge linkClk);
		clkRun = 1'b0;
	end
	// One byte access: drive after an edge, hold one cycle, wait for the ack
	task automatic access(input rpe_op_t op, input logic nw, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] dv;
		int n;
		dv = d;
		if (op == RPE_OP_WRITE && nw && a == 8'h00 && dv[2:0] > PAGE_LAST_SPI) begin
			dv[2:0] = PAGE_LAST_SPI;
		end
		@(posedge linkClk);
		for (n = 0; n < 40 && !linkReady; n++) begin
			@(posedge linkClk);
		end
		if (n >= 40) begin
			timedOut = 1'b1;
		end
		linkReq <= 1'b1;
		linkOp <= op;
		linkNewAddr <= nw;
		linkAddr <= a;
		linkData <= dv;
		@(posedge linkClk);
		linkReq <= 1'b0;
		linkOp <= RPE_OP_NONE;
		linkAddr <= ~a;
		linkData <= ~dv;
		for (n = 0; n < 20; n++) begin
			@(posedge linkClk);
			if (linkRdValid) begin
				lastRead = linkRdData;
			end
			if (linkReady) begin
				break;
			end
		end
		if (n >= 20) begin
			timedOut = 1'b1;
		end
	endtask
	// Frame start and end; the clock keeps running for 8 edges after the end ack lands
	task automatic open(input logic fw);
		linkFourWire = fw;
		clkRun = 1'b1;
	endtask
	task automatic close();
		access(RPE_OP_END, 1'b0, 8'h00, 8'h00);
		repeat (8) @(posedge linkClk);
		clkRun = 1'b0;
	endtask
	// Events are cleared by writing back exactly what was read
	task automatic clear_events(input logic [7:0] a);
		access(RPE_OP_READ, 1'b1, a, 8'h00);
		access(RPE_OP_WRITE, 1'b1, a, lastRead);
	endtask
endmodule

// File: verification/testbench.sv
// Purpose: self-checking bench for paging, status, events and interrupt
// Assumes: inputs change on the falling core clock edge
// Notes: a pin held high across reset must raise no event
`timescale 1ns/1ps
module testbench;
	import rpe_pkg::*;
	logic core_clk, arst_n, linkClk, linkReq, linkNewAddr, linkFourWire, linkReady, linkRdValid;
	rpe_op_t linkOp;
	logic [7:0] linkAddr, linkData, linkRdData;
	logic [4:0] generalInput, inputActiveHigh;
	logic rampA, rampB, climA, climB, tsd, twarn, rngA, rngB, uv, interruptOutLow;
	int fails, checksDone;
	rpe_core dut_u (.core_clk(core_clk), .arst_n(arst_n), .linkClk(linkClk), .linkReq(linkReq),
		.linkOp(linkOp), .linkNewAddr(linkNewAddr), .linkAddr(linkAddr), .linkData(linkData),
		.linkFourWire(linkFourWire), .linkReady(linkReady), .linkRdData(linkRdData),
		.linkRdValid(linkRdValid), .generalInput(generalInput), .inputActiveHigh(inputActiveHigh),
		.voltageRampFirst(rampA), .voltageRampSecond(rampB), .currentLimitFirst(climA),
		.currentLimitSecond(climB), .thermalShutdownFlag(tsd), .thermalWarning(twarn),
		.outputInRangeFirst(rngA), .outputInRangeSecond(rngB), .ioSupplyUndervoltage(uv),
		.interruptOutLow(interruptOutLow));
	rpe_link_host host_u (.linkClk(linkClk), .linkReq(linkReq), .linkOp(linkOp), .linkNewAddr(linkNewAddr),
		.linkAddr(linkAddr), .linkData(linkData), .linkFourWire(linkFourWire), .linkReady(linkReady),
		.linkRdData(linkRdData), .linkRdValid(linkRdValid));
	// Core clock at 40 MHz
	always #12.5 core_clk = ~core_clk;
	// ------------------------------------------------------------
	// Compare, access and closing helpers
	// ------------------------------------------------------------
	task automatic finish_test();
		if (host_u.timedOut) begin
			fails++;
		end
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkbit(input logic got, input logic exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// A lost ack ends the run at once
	task automatic lnk(input rpe_op_t op, input logic nw, input logic [7:0] a, input logic [7:0] d);
		host_u.access(op, nw, a, d);
		if (host_u.timedOut) begin
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		lnk(RPE_OP_WRITE, 1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		lnk(RPE_OP_READ, 1'b1, a, 8'h00);
		chk8(host_u.lastRead, exp);
	endtask
	// Bounded wait for the interrupt level, then judged
	task automatic wait_irq(input logic exp);
		int n;
		for (n = 0; n < 40 && interruptOutLow !== exp; n++) begin
			@(negedge core_clk);
		end
		chkbit(interruptOutLow, exp);
	endtask
	// Monitored pins, changed together at the falling edge
	task automatic drive_mon(input logic [4:0] g, input logic [8:0] s);
		@(negedge core_clk);
		generalInput = g;
		rampA = s[8];
		rampB = s[7];
		climA = s[6];
		climB = s[5];
		tsd = s[4];
		twarn = s[3];
		rngA = s[2];
		rngB = s[1];
		uv = s[0];
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_regs();
		host_u.open(1'b0);
		rd(8'h00, RST_PAGE_CTL);
		rd(8'h52, RST_EVENT);
		rd(8'h55, RST_MASK);
		wr(8'h54, 8'hFF);
		rd(8'h54, EVIN_USED);
		wr(8'h55, 8'hFF);
		rd(8'h55, EVREG_USED);
		wr(8'h54, 8'h00);
		wr(8'h55, 8'h00);
		rd(8'h51, 8'hC3);
		host_u.close();
		drive_mon(5'h00, 9'h006);
	endtask
	task automatic test_paging();
		host_u.open(1'b1);
		wr(8'h00, 8'h01);
		rd(8'h00, 8'h01);
		rd(8'h51, 8'h00);
		wr(8'h00, 8'h02);
		rd(8'h00, 8'h02);
		wr(8'h00, 8'h00);
		rd(8'h51, 8'hC3);
		host_u.close();
		host_u.open(1'b0);
		wr(8'h00, 8'h82);
		rd(8'h00, 8'h82);
		rd(8'h80, 8'h00);
		host_u.close();
		host_u.open(1'b0);
		rd(8'h00, 8'h80);
		wr(8'h00, 8'h01);
		rd(8'h51, 8'hC3);
		wr(8'h00, 8'h00);
		host_u.close();
	endtask
	task automatic test_write_mode();
		host_u.open(1'b0);
		wr(8'h00, 8'h40);
		host_u.close();
		host_u.open(1'b0);
		wr(8'h54, 8'h01);
		lnk(RPE_OP_WRITE, 1'b0, 8'h00, 8'h55);
		lnk(RPE_OP_WRITE, 1'b0, 8'h00, 8'h02);
		rd(8'h54, 8'h01);
		rd(8'h55, 8'h02);
		host_u.close();
		host_u.open(1'b1);
		wr(8'h54, 8'h03);
		lnk(RPE_OP_WRITE, 1'b0, 8'h00, 8'h07);
		rd(8'h55, 8'h07);
		wr(8'h00, 8'h00);
		host_u.close();
		host_u.open(1'b0);
		wr(8'h54, 8'h00);
		lnk(RPE_OP_WRITE, 1'b0, 8'h00, 8'h00);
		rd(8'h55, 8'h00);
		host_u.close();
	endtask
	task automatic test_status_events();
		drive_mon(5'h15, 9'h1B8);
		repeat (6) @(negedge core_clk);
		host_u.open(1'b0);
		rd(8'h50, 8'h15);
		rd(8'h51, 8'h2C);
		rd(8'h52, 8'h11);
		host_u.close();
		drive_mon(5'h00, 9'h006);
		wait_irq(1'b0);
		host_u.open(1'b0);
		rd(8'h52, 8'h15);
		rd(8'h53, 8'h2F);
		host_u.clear_events(8'h52);
		chkbit(interruptOutLow, 1'b0);
		host_u.clear_events(8'h53);
		host_u.close();
		wait_irq(1'b1);
		host_u.open(1'b0);
		rd(8'h53, 8'h00);
		host_u.close();
	endtask
	// Opposite polarities toggled together give an event every core cycle during the clear
	task automatic test_clear_race();
		host_u.open(1'b0);
		fork
			for (int n = 0; n < 60; n++) begin
				@(negedge core_clk);
				generalInput = generalInput ^ 5'h05;
			end
			host_u.clear_events(8'h52);
		join
		rd(8'h52, 8'h05);
		host_u.clear_events(8'h52);
		rd(8'h52, 8'h00);
		host_u.close();
		wait_irq(1'b1);
	endtask
	task automatic test_masks();
		host_u.open(1'b0);
		wr(8'h55, 8'h14);
		wr(8'h54, 8'h44);
		host_u.close();
		@(negedge core_clk);
		inputActiveHigh = 5'h1F;
		drive_mon(5'h04, 9'h04F);
		repeat (20) @(negedge core_clk);
		chkbit(interruptOutLow, 1'b1);
		host_u.open(1'b0);
		rd(8'h53, 8'h04);
		rd(8'h52, 8'h44);
		wr(8'h54, 8'h00);
		host_u.close();
		wait_irq(1'b0);
		host_u.open(1'b0);
		host_u.clear_events(8'h52);
		host_u.clear_events(8'h53);
		wr(8'h55, 8'h00);
		host_u.close();
		wait_irq(1'b1);
		drive_mon(5'h00, 9'h006);
	endtask
	// Main sequence
	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		fails = 0;
		checksDone = 0;
		inputActiveHigh = 5'h1B;
		// Input 0 sits high across reset: its release must not look like an edge
		drive_mon(5'h01, 9'h006);
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		test_regs();
		test_paging();
		test_write_mode();
		test_status_events();
		test_clear_race();
		test_masks();
		finish_test();
	end
endmodule
